// File: src/cbd_sequencer.sv
// Decode and execution-timing sequencer for move, branch and bit instructions
// Operation
// RULE_01: 0xE8-0xEF register to accumulator, 1 byte, 1 cycle
// RULE_02: 0xF8-0xFF accumulator to register, 1 byte, 2 cycles
// RULE_03: 0xA8-0xAF direct to register, 2 bytes, 4 cycles
// RULE_04: 0x85 direct to direct, 3 bytes, 4 cycles
// RULE_05: 0x90 load data pointer, 3 bytes, 3 cycles
// RULE_06: 0x93/0x83 code byte load, 3 cycles
// RULE_07: 0xE2-0xE3/0xE0 external read, 4 cycles
// RULE_08: 0xF2-0xF3/0xF0 external write, 5 cycles
// RULE_09: Power control bit 4 selects external move action
// RULE_10: Push 0xC0 four cycles, pop 0xD0 three
// RULE_11: 0xD6-0xD7 low nibble exchange, 3 cycles
// RULE_12: 0xC8-0xCF byte swap with accumulator, 2 cycles
// RULE_13: 0x80 short relative jump, 2 bytes, 3 cycles
// RULE_14: 0x73 jump accumulator plus data pointer, 2 cycles
// RULE_15: 0x60/0x70 branch on accumulator zero/nonzero
// RULE_16: 0x40/0x50 branch on carry set/clear
// RULE_17: 0x20/0x30 branch on bit one/zero, 4 cycles
// RULE_18: 0x10 branch on set bit and clear it
// RULE_19: 0xB5/0xB4/0xB8-0xBF compare, branch if unequal
// RULE_20: 0xD8-0xDF/0xD5 decrement, branch if nonzero
// RULE_21: 0xC2/0xD2/0xB2 clear, set, invert bit
// RULE_22: 0x82/0x72/0xB0/0xA0 bit logic into carry, 2 cycles
// RULE_23: Register index from low opcode bits
// RULE_24: Next fetch only after listed cycle count
`timescale 1ns/100ps
module cbd_sequencer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Opcode fetch from program memory
	output logic fetch_req,
	input wire logic fetch_valid,
	input wire logic [7:0] fetch_data,
	// Datapath conditions, valid in the last busy cycle
	input wire logic acc_is_zero,
	input wire logic carry_flag,
	input wire logic addr_bit,
	input wire logic compare_unequal,
	input wire logic decrement_nonzero,
	// Power control register contents
	input wire logic [7:0] pcon_value,
	// Decoded instruction
	output cbd_pkg::cbd_op_t op_code,
	output logic [1:0] instr_len,
	output logic [2:0] instr_cycles,
	output logic [2:0] reg_idx,
	output logic unsupported,
	output logic busy,
	output logic done,
	// Branch and bit results
	output logic branch_taken,
	output logic bit_we,
	output logic bit_val,
	output logic carry_we,
	output logic carry_val,
	// External data move control
	output logic ext_rd,
	output logic ext_wr,
	output logic ext_wide_addr,
	output logic ext_to_code
);

	typedef struct packed {
		cbd_pkg::cbd_phase_t ph;
		logic [2:0] cnt;
		cbd_pkg::cbd_op_t op;
		logic [1:0] len;
		logic [2:0] cyc;
		logic [2:0] reg_idx;
		logic unsup;
		logic fetch_req;
		logic busy;
		logic done;
		logic taken;
		logic bit_we;
		logic bit_val;
		logic carry_we;
		logic carry_val;
		logic ext_rd;
		logic ext_wr;
		logic ext_wide;
		logic ext_code;
	} cbd_state_t;

	cbd_state_t s_q;
	cbd_state_t s_d;
	cbd_pkg::cbd_op_t dec_op;
	logic [1:0] dec_len;
	logic [2:0] dec_cyc;
	logic [2:0] dec_reg;
	logic dec_known;
	logic take;

	cbd_decode u_decode (
		.opcode(fetch_data),
		.op(dec_op),
		.len(dec_len),
		.cyc(dec_cyc),
		.reg_idx(dec_reg),
		.known(dec_known)
	);

	assign take = s_q.fetch_req && fetch_valid;

	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.taken = 1'b0;
		s_d.bit_we = 1'b0;
		s_d.carry_we = 1'b0;
		unique case (s_q.ph)
			cbd_pkg::PH_FETCH:
			begin
				if (take)
				begin
					s_d.ph = cbd_pkg::PH_EXEC;
					s_d.fetch_req = 1'b0;
					s_d.busy = 1'b1;
					s_d.op = dec_op;
					s_d.len = dec_len;
					s_d.cyc = dec_cyc;
					s_d.cnt = dec_cyc - 3'h1;
					s_d.reg_idx = dec_reg;
					s_d.unsup = !dec_known;
					s_d.ext_rd = (dec_op == cbd_pkg::OP_XDATA_RD_IND) ||
						(dec_op == cbd_pkg::OP_XDATA_RD_DP); // RULE_07
					s_d.ext_wr = (dec_op == cbd_pkg::OP_XDATA_WR_IND) ||
						(dec_op == cbd_pkg::OP_XDATA_WR_DP); // RULE_08
					s_d.ext_wide = (dec_op == cbd_pkg::OP_XDATA_RD_DP) ||
						(dec_op == cbd_pkg::OP_XDATA_WR_DP);
					// Program-memory write select chooses the external move target
					s_d.ext_code = pcon_value[cbd_pkg::PCON_PMW_BIT]; // RULE_09
				end
			end
			cbd_pkg::PH_EXEC:
			begin
				if (s_q.cnt == cbd_pkg::CNT_RST)
				begin
					// Last cycle: resolve outcome, then allow the next fetch
					s_d.ph = cbd_pkg::PH_FETCH;
					s_d.busy = 1'b0;
					s_d.done = 1'b1;
					s_d.fetch_req = 1'b1; // RULE_24
					s_d.ext_rd = 1'b0;
					s_d.ext_wr = 1'b0;
					case (s_q.op)
						cbd_pkg::OP_SHORT_RELATIVE_JUMP: s_d.taken = 1'b1; // RULE_13
						cbd_pkg::OP_JUMP_ACC_PLUS_DP: s_d.taken = 1'b1; // RULE_14
						cbd_pkg::OP_BRANCH_IF_ACC_ZERO: s_d.taken = acc_is_zero; // RULE_15
						cbd_pkg::OP_BRANCH_IF_ACC_NONZERO: s_d.taken = !acc_is_zero; // RULE_15
						cbd_pkg::OP_BRANCH_IF_CARRY: s_d.taken = carry_flag; // RULE_16
						cbd_pkg::OP_BRANCH_IF_NO_CARRY: s_d.taken = !carry_flag; // RULE_16
						cbd_pkg::OP_BRANCH_IF_BIT_ONE: s_d.taken = addr_bit; // RULE_17
						cbd_pkg::OP_BRANCH_IF_BIT_ZERO: s_d.taken = !addr_bit; // RULE_17
						cbd_pkg::OP_BRANCH_AND_CLEAR_BIT:
						begin
							s_d.taken = addr_bit; // RULE_18
							s_d.bit_we = addr_bit; // RULE_18
							s_d.bit_val = 1'b0;
						end
						cbd_pkg::OP_CMP_BRANCH_DIR,
						cbd_pkg::OP_CMP_BRANCH_IMM,
						cbd_pkg::OP_CMP_BRANCH_REG: s_d.taken = compare_unequal; // RULE_19
						cbd_pkg::OP_DEC_BRANCH_REG,
						cbd_pkg::OP_DEC_BRANCH_DIR: s_d.taken = decrement_nonzero; // RULE_20
						cbd_pkg::OP_BIT_CLEAR_OP:
						begin
							s_d.bit_we = 1'b1; // RULE_21
							s_d.bit_val = 1'b0;
						end
						cbd_pkg::OP_BIT_SET_OP:
						begin
							s_d.bit_we = 1'b1; // RULE_21
							s_d.bit_val = 1'b1;
						end
						cbd_pkg::OP_BIT_INVERT_OP:
						begin
							s_d.bit_we = 1'b1; // RULE_21
							s_d.bit_val = !addr_bit;
						end
						cbd_pkg::OP_LOGICAL_AND_BIT:
						begin
							s_d.carry_we = 1'b1; // RULE_22
							s_d.carry_val = carry_flag & addr_bit;
						end
						cbd_pkg::OP_LOGICAL_OR_BIT:
						begin
							s_d.carry_we = 1'b1; // RULE_22
							s_d.carry_val = carry_flag | addr_bit;
						end
						cbd_pkg::OP_LOGICAL_AND_NBIT:
						begin
							s_d.carry_we = 1'b1; // RULE_22
							s_d.carry_val = carry_flag & !addr_bit;
						end
						cbd_pkg::OP_LOGICAL_OR_NBIT:
						begin
							s_d.carry_we = 1'b1; // RULE_22
							s_d.carry_val = carry_flag | !addr_bit;
						end
						default: s_d.taken = 1'b0;
					endcase
				end
				else
				begin
					s_d.cnt = s_q.cnt - 3'h1; // RULE_24
				end
			end
			default:
			begin
				s_d.ph = cbd_pkg::PH_FETCH;
				s_d.fetch_req = 1'b1;
				s_d.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_q <= '0;
			s_q.ph <= cbd_pkg::PH_FETCH;
			s_q.fetch_req <= 1'b1;
			s_q.op <= cbd_pkg::OP_NONE;
			s_q.cnt <= cbd_pkg::CNT_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign fetch_req = s_q.fetch_req;
	assign op_code = s_q.op;
	assign instr_len = s_q.len;
	assign instr_cycles = s_q.cyc;
	assign reg_idx = s_q.reg_idx;
	assign unsupported = s_q.unsup;
	assign busy = s_q.busy;
	assign done = s_q.done;
	assign branch_taken = s_q.taken;
	assign bit_we = s_q.bit_we;
	assign bit_val = s_q.bit_val;
	assign carry_we = s_q.carry_we;
	assign carry_val = s_q.carry_val;
	assign ext_rd = s_q.ext_rd;
	assign ext_wr = s_q.ext_wr;
	assign ext_wide_addr = s_q.ext_wide;
	assign ext_to_code = s_q.ext_code;

	// Busy-cycle counter used only by the checks below
	logic [2:0] run_q;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			run_q <= 3'h0;
		end
		else if (take)
		begin
			run_q <= 3'h0;
		end
		else if (s_q.busy)
		begin
			run_q <= run_q + 3'h1;
		end
	end

	property p_busy_span;
		@(posedge sys_clk) disable iff (!resetn)
		s_q.done |-> (run_q == s_q.cyc) && !s_q.busy && s_q.fetch_req;
	endproperty
	a_busy_span: assert property (p_busy_span) // RULE_24
		else $error("busy span differs from instruction cycle count");

	property p_no_fetch_busy;
		@(posedge sys_clk) disable iff (!resetn)
		s_q.busy |-> !s_q.fetch_req;
	endproperty
	a_no_fetch_busy: assert property (p_no_fetch_busy) // RULE_24
		else $error("fetch requested while an instruction is executing");

	property p_mov_a_reg;
		@(posedge sys_clk) disable iff (!resetn)
		take && (fetch_data[7:3] == 5'h1D) |=> s_q.busy && (s_q.cyc == 3'h1)
			&& (s_q.len == 2'h1) && (s_q.reg_idx == $past(fetch_data[2:0])) ##1 s_q.done;
	endproperty
	a_mov_a_reg: assert property (p_mov_a_reg) // RULE_01
		else $error("register to accumulator move timing wrong");

	property p_mov_reg_a;
		@(posedge sys_clk) disable iff (!resetn)
		take && (fetch_data[7:3] == 5'h1F) |=> s_q.busy [*2] ##1 s_q.done;
	endproperty
	a_mov_reg_a: assert property (p_mov_reg_a) // RULE_02
		else $error("accumulator to register move not two cycles");

	property p_ext_write;
		@(posedge sys_clk) disable iff (!resetn)
		take && (fetch_data == 8'hF0) |=> (s_q.ext_wr && s_q.ext_wide) [*5] ##1 s_q.done;
	endproperty
	a_ext_write: assert property (p_ext_write) // RULE_08
		else $error("wide external write not held five cycles");

	property p_ext_read;
		@(posedge sys_clk) disable iff (!resetn)
		take && (fetch_data[7:1] == 7'h71) |=> (s_q.ext_rd && !s_q.ext_wide) [*4]
			##1 s_q.done;
	endproperty
	a_ext_read: assert property (p_ext_read) // RULE_07
		else $error("narrow external read not held four cycles");

	property p_pmw_select;
		@(posedge sys_clk) disable iff (!resetn)
		take |=> s_q.ext_code == $past(pcon_value[4]);
	endproperty
	a_pmw_select: assert property (p_pmw_select) // RULE_09
		else $error("external move target not taken from power control bit");

	property p_acc_zero_branch;
		@(posedge sys_clk) disable iff (!resetn)
		s_q.done && (s_q.op == cbd_pkg::OP_BRANCH_IF_ACC_ZERO)
			|-> s_q.taken == $past(acc_is_zero);
	endproperty
	a_acc_zero_branch: assert property (p_acc_zero_branch) // RULE_15
		else $error("accumulator zero branch decision wrong");

	property p_clear_on_branch;
		@(posedge sys_clk) disable iff (!resetn)
		s_q.done && (s_q.op == cbd_pkg::OP_BRANCH_AND_CLEAR_BIT) |-> (s_q.taken == s_q.bit_we)
			&& !s_q.bit_val && (s_q.cyc == 3'h4) && (s_q.len == 2'h3);
	endproperty
	a_clear_on_branch: assert property (p_clear_on_branch) // RULE_18
		else $error("branch with bit clear did not clear exactly when taken");

	property p_carry_logic;
		@(posedge sys_clk) disable iff (!resetn)
		take && (fetch_data == 8'hB0) |=> s_q.busy ##1 s_q.busy ##1
			(s_q.carry_we && (s_q.carry_val == ($past(carry_flag) & !$past(addr_bit))));
	endproperty
	a_carry_logic: assert property (p_carry_logic) // RULE_22
		else $error("and with inverted bit into carry wrong");

	property p_dec_branch_dir;
		@(posedge sys_clk) disable iff (!resetn)
		take && (fetch_data == 8'hD5) |=> s_q.busy [*4] ##1
			(s_q.done && (s_q.taken == $past(decrement_nonzero)));
	endproperty
	a_dec_branch_dir: assert property (p_dec_branch_dir) // RULE_20
		else $error("direct decrement branch timing or decision wrong");

endmodule : cbd_sequencer

// File: src/cbd_pkg.sv
// Shared operation codes, lengths, cycle counts and phase codes for the decoder and sequencer
package cbd_pkg;

	// Instruction lengths in bytes
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;

	// Execution times in core cycles
	localparam logic [2:0] CYC_1 = 3'h1;
	localparam logic [2:0] CYC_2 = 3'h2;
	localparam logic [2:0] CYC_3 = 3'h3;
	localparam logic [2:0] CYC_4 = 3'h4;
	localparam logic [2:0] CYC_5 = 3'h5;

	// Field positions inside an opcode
	localparam int REG_IDX_MSB = 2;
	localparam int RANGE_LSB = 3;

	// Power control bit that steers external moves to program memory
	localparam int PCON_PMW_BIT = 4;

	// Reset values
	localparam logic [2:0] CNT_RST = 3'h0;
	localparam logic [2:0] REG_IDX_RST = 3'h0;

	typedef enum logic [5:0] {
		OP_NONE = 6'h00,
		OP_MOV_A_REG = 6'h01,
		OP_MOV_REG_A = 6'h02,
		OP_MOV_REG_DIR = 6'h03,
		OP_MOV_DIR_DIR = 6'h04,
		OP_LOAD_DATA_POINTER = 6'h05,
		OP_CODE_BYTE_LOAD_DP = 6'h06,
		OP_CODE_BYTE_LOAD_PC = 6'h07,
		OP_XDATA_RD_IND = 6'h08,
		OP_XDATA_RD_DP = 6'h09,
		OP_XDATA_WR_IND = 6'h0A,
		OP_XDATA_WR_DP = 6'h0B,
		OP_STACK_PUSH = 6'h0C,
		OP_STACK_POP = 6'h0D,
		OP_NIBBLE_EXCHANGE = 6'h0E,
		OP_BYTE_SWAP_WITH_ACC = 6'h0F,
		OP_SHORT_RELATIVE_JUMP = 6'h10,
		OP_JUMP_ACC_PLUS_DP = 6'h11,
		OP_BRANCH_IF_ACC_ZERO = 6'h12,
		OP_BRANCH_IF_ACC_NONZERO = 6'h13,
		OP_BRANCH_IF_CARRY = 6'h14,
		OP_BRANCH_IF_NO_CARRY = 6'h15,
		OP_BRANCH_IF_BIT_ONE = 6'h16,
		OP_BRANCH_IF_BIT_ZERO = 6'h17,
		OP_BRANCH_AND_CLEAR_BIT = 6'h18,
		OP_CMP_BRANCH_DIR = 6'h19,
		OP_CMP_BRANCH_IMM = 6'h1A,
		OP_CMP_BRANCH_REG = 6'h1B,
		OP_DEC_BRANCH_REG = 6'h1C,
		OP_DEC_BRANCH_DIR = 6'h1D,
		OP_BIT_CLEAR_OP = 6'h1E,
		OP_BIT_SET_OP = 6'h1F,
		OP_BIT_INVERT_OP = 6'h20,
		OP_LOGICAL_AND_BIT = 6'h21,
		OP_LOGICAL_OR_BIT = 6'h22,
		OP_LOGICAL_AND_NBIT = 6'h23,
		OP_LOGICAL_OR_NBIT = 6'h24
	} cbd_op_t;

	typedef enum logic [1:0] {
		PH_FETCH = 2'b01,
		PH_EXEC = 2'b10
	} cbd_phase_t;

endpackage : cbd_pkg

// File: src/cbd_decode.sv
// Opcode to operation, length, cycle count and register index table
`timescale 1ns/100ps
module cbd_decode (
	// Opcode in
	input wire logic [7:0] opcode,
	// Decoded fields
	output cbd_pkg::cbd_op_t op,
	output logic [1:0] len,
	output logic [2:0] cyc,
	output logic [2:0] reg_idx,
	output logic known
);

	logic [4:0] range;

	assign range = opcode[7:cbd_pkg::RANGE_LSB];

	always_comb
	begin
		op = cbd_pkg::OP_NONE;
		len = cbd_pkg::LEN_1;
		cyc = cbd_pkg::CYC_1;
		known = 1'b1;
		reg_idx = cbd_pkg::REG_IDX_RST;
		// Register ranges carry the index in the low three bits
		if (range == 5'h1D)
		begin
			op = cbd_pkg::OP_MOV_A_REG; // RULE_01
			reg_idx = opcode[cbd_pkg::REG_IDX_MSB:0]; // RULE_23
		end
		else if (range == 5'h1F)
		begin
			op = cbd_pkg::OP_MOV_REG_A; // RULE_02
			cyc = cbd_pkg::CYC_2;
			reg_idx = opcode[cbd_pkg::REG_IDX_MSB:0]; // RULE_23
		end
		else if (range == 5'h15)
		begin
			op = cbd_pkg::OP_MOV_REG_DIR; // RULE_03
			len = cbd_pkg::LEN_2;
			cyc = cbd_pkg::CYC_4;
			reg_idx = opcode[cbd_pkg::REG_IDX_MSB:0]; // RULE_23
		end
		else if (range == 5'h19)
		begin
			op = cbd_pkg::OP_BYTE_SWAP_WITH_ACC; // RULE_12
			cyc = cbd_pkg::CYC_2;
			reg_idx = opcode[cbd_pkg::REG_IDX_MSB:0]; // RULE_23
		end
		else if (range == 5'h17)
		begin
			op = cbd_pkg::OP_CMP_BRANCH_REG; // RULE_19
			len = cbd_pkg::LEN_3;
			cyc = cbd_pkg::CYC_4;
			reg_idx = opcode[cbd_pkg::REG_IDX_MSB:0]; // RULE_23
		end
		else if (range == 5'h1B)
		begin
			op = cbd_pkg::OP_DEC_BRANCH_REG; // RULE_20
			len = cbd_pkg::LEN_2;
			cyc = cbd_pkg::CYC_3;
			reg_idx = opcode[cbd_pkg::REG_IDX_MSB:0]; // RULE_23
		end
		else
		begin
			// Indirect pointer forms take their index from bit 0
			reg_idx = {2'h0, opcode[0]}; // RULE_23
			case (opcode)
				8'h85: begin op = cbd_pkg::OP_MOV_DIR_DIR; len = cbd_pkg::LEN_3; cyc = cbd_pkg::CYC_4; end // RULE_04
				8'h90: begin op = cbd_pkg::OP_LOAD_DATA_POINTER; len = cbd_pkg::LEN_3; cyc = cbd_pkg::CYC_3; end // RULE_05
				8'h93: begin op = cbd_pkg::OP_CODE_BYTE_LOAD_DP; cyc = cbd_pkg::CYC_3; end // RULE_06
				8'h83: begin op = cbd_pkg::OP_CODE_BYTE_LOAD_PC; cyc = cbd_pkg::CYC_3; end // RULE_06
				8'hE2, 8'hE3: begin op = cbd_pkg::OP_XDATA_RD_IND; cyc = cbd_pkg::CYC_4; end // RULE_07
				8'hE0: begin op = cbd_pkg::OP_XDATA_RD_DP; cyc = cbd_pkg::CYC_4; end // RULE_07
				8'hF2, 8'hF3: begin op = cbd_pkg::OP_XDATA_WR_IND; cyc = cbd_pkg::CYC_5; end // RULE_08
				8'hF0: begin op = cbd_pkg::OP_XDATA_WR_DP; cyc = cbd_pkg::CYC_5; end // RULE_08
				8'hC0: begin op = cbd_pkg::OP_STACK_PUSH; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_4; end // RULE_10
				8'hD0: begin op = cbd_pkg::OP_STACK_POP; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_3; end // RULE_10
				8'hD6, 8'hD7: begin op = cbd_pkg::OP_NIBBLE_EXCHANGE; cyc = cbd_pkg::CYC_3; end // RULE_11
				8'h80: begin op = cbd_pkg::OP_SHORT_RELATIVE_JUMP; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_3; end // RULE_13
				8'h73: begin op = cbd_pkg::OP_JUMP_ACC_PLUS_DP; cyc = cbd_pkg::CYC_2; end // RULE_14
				8'h60: begin op = cbd_pkg::OP_BRANCH_IF_ACC_ZERO; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_3; end // RULE_15
				8'h70: begin op = cbd_pkg::OP_BRANCH_IF_ACC_NONZERO; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_3; end // RULE_15
				8'h40: begin op = cbd_pkg::OP_BRANCH_IF_CARRY; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_3; end // RULE_16
				8'h50: begin op = cbd_pkg::OP_BRANCH_IF_NO_CARRY; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_3; end // RULE_16
				8'h20: begin op = cbd_pkg::OP_BRANCH_IF_BIT_ONE; len = cbd_pkg::LEN_3; cyc = cbd_pkg::CYC_4; end // RULE_17
				8'h30: begin op = cbd_pkg::OP_BRANCH_IF_BIT_ZERO; len = cbd_pkg::LEN_3; cyc = cbd_pkg::CYC_4; end // RULE_17
				8'h10: begin op = cbd_pkg::OP_BRANCH_AND_CLEAR_BIT; len = cbd_pkg::LEN_3; cyc = cbd_pkg::CYC_4; end // RULE_18
				8'hB5: begin op = cbd_pkg::OP_CMP_BRANCH_DIR; len = cbd_pkg::LEN_3; cyc = cbd_pkg::CYC_4; end // RULE_19
				8'hB4: begin op = cbd_pkg::OP_CMP_BRANCH_IMM; len = cbd_pkg::LEN_3; cyc = cbd_pkg::CYC_4; end // RULE_19
				8'hD5: begin op = cbd_pkg::OP_DEC_BRANCH_DIR; len = cbd_pkg::LEN_3; cyc = cbd_pkg::CYC_4; end // RULE_20
				8'hC2: begin op = cbd_pkg::OP_BIT_CLEAR_OP; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_3; end // RULE_21
				8'hD2: begin op = cbd_pkg::OP_BIT_SET_OP; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_3; end // RULE_21
				8'hB2: begin op = cbd_pkg::OP_BIT_INVERT_OP; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_3; end // RULE_21
				8'h82: begin op = cbd_pkg::OP_LOGICAL_AND_BIT; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_2; end // RULE_22
				8'h72: begin op = cbd_pkg::OP_LOGICAL_OR_BIT; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_2; end // RULE_22
				8'hB0: begin op = cbd_pkg::OP_LOGICAL_AND_NBIT; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_2; end // RULE_22
				8'hA0: begin op = cbd_pkg::OP_LOGICAL_OR_NBIT; len = cbd_pkg::LEN_2; cyc = cbd_pkg::CYC_2; end // RULE_22
				default: known = 1'b0;
			endcase
		end
	end

endmodule : cbd_decode

// File: tb/cbd_prog_mem.sv
// Program memory model that offers opcode bytes to the sequencer
`timescale 1ns/100ps
module cbd_prog_mem (
	// Clock
	input wire logic sys_clk,
	// Bench control
	input wire logic run,
	input wire logic hold_off,
	input wire logic [8:0] prog_len,
	// Opcode fetch handshake
	input wire logic fetch_req,
	output logic fetch_valid,
	output logic [7:0] fetch_data
);
	logic [7:0] prog [0:255];
	int ptr = 0;
	logic take, go, ho, nv;

	initial
	begin
		fetch_valid = 1'h0;
		fetch_data = 8'hA5;
	end

	always @(posedge sys_clk)
	begin
		take = fetch_valid && fetch_req;
		go = run;
		ho = hold_off;
		#1;
		// An offer stands until the sequencer takes it
		nv = fetch_valid && !take;
		if (take)
			ptr++;
		if (!go)
		begin
			ptr = 0;
			nv = 1'h0;
		end
		else if (!nv && ptr < prog_len && !ho)
			nv = 1'h1;
		fetch_valid <= nv;
		// Without an offer the byte lane toggles so stale data is never reused
		fetch_data <= nv ? prog[ptr] : ~fetch_data;
	end
endmodule : cbd_prog_mem

// File: tb/tb_cbd_sequencer.sv
// Self-checking bench for the move, branch and bit instruction sequencer
`timescale 1ns/100ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_cbd_sequencer;
	logic sys_clk = 1'h0;
	logic resetn = 1'h0;
	logic fetch_req, fetch_valid, busy, done, unsupported;
	logic [7:0] fetch_data;
	logic acc_is_zero = 1'h0, carry_flag = 1'h0, addr_bit = 1'h0;
	logic compare_unequal = 1'h0, decrement_nonzero = 1'h0;
	logic [7:0] pcon_value = 8'h00;
	cbd_pkg::cbd_op_t op_code;
	logic [1:0] instr_len;
	logic [2:0] instr_cycles, reg_idx;
	logic branch_taken, bit_we, bit_val, carry_we, carry_val;
	logic ext_rd, ext_wr, ext_wide_addr, ext_to_code;
	logic run = 1'h0, hold_off = 1'h0, slow = 1'h0;
	logic [8:0] prog_len = 9'h000;
	integer seed = 32'hC144;
	int n_fail = 0, checks = 0, n_done = 0, i;
	cbd_pkg::cbd_op_t e_op = cbd_pkg::OP_NONE;
	logic [1:0] e_len;
	logic [2:0] e_cyc = 3'h0, e_idx;
	logic [3:0] cnt = 4'h0;
	logic e_uns, e_pmw, xr = 1'h0, xw = 1'h0, xwide, e_br, e_bwe, e_bv, e_cwe, e_cv;
	logic [31:0] r;

	always #4 sys_clk = ~sys_clk;

	cbd_sequencer i_dut (.sys_clk, .resetn, .fetch_req, .fetch_valid, .fetch_data,
		.acc_is_zero, .carry_flag, .addr_bit, .compare_unequal, .decrement_nonzero,
		.pcon_value, .op_code, .instr_len, .instr_cycles, .reg_idx, .unsupported, .busy,
		.done, .branch_taken, .bit_we, .bit_val, .carry_we, .carry_val, .ext_rd, .ext_wr,
		.ext_wide_addr, .ext_to_code);
	cbd_prog_mem i_mem (.sys_clk, .run, .hold_off, .prog_len, .fetch_req, .fetch_valid,
		.fetch_data);

	task automatic sx(input cbd_pkg::cbd_op_t p, input logic [1:0] l, input logic [2:0] c);
		e_op = p;
		e_len = l;
		e_cyc = c;
	endtask : sx

	task automatic ref_dec(input logic [7:0] o);
		e_idx = (o[3] && o[7:4] >= 4'hA) ? o[2:0] : {2'h0, o[0]};
		xr = o inside {8'hE0, 8'hE2, 8'hE3};
		xw = o inside {8'hF0, 8'hF2, 8'hF3};
		xwide = o == 8'hE0 || o == 8'hF0;
		casez (o)
		8'b1110_1???: sx(cbd_pkg::OP_MOV_A_REG, 2'h1, 3'h1);
		8'b1111_1???: sx(cbd_pkg::OP_MOV_REG_A, 2'h1, 3'h2);
		8'b1010_1???: sx(cbd_pkg::OP_MOV_REG_DIR, 2'h2, 3'h4);
		8'h85: sx(cbd_pkg::OP_MOV_DIR_DIR, 2'h3, 3'h4);
		8'h90: sx(cbd_pkg::OP_LOAD_DATA_POINTER, 2'h3, 3'h3);
		8'h93: sx(cbd_pkg::OP_CODE_BYTE_LOAD_DP, 2'h1, 3'h3);
		8'h83: sx(cbd_pkg::OP_CODE_BYTE_LOAD_PC, 2'h1, 3'h3);
		8'hE2, 8'hE3: sx(cbd_pkg::OP_XDATA_RD_IND, 2'h1, 3'h4);
		8'hE0: sx(cbd_pkg::OP_XDATA_RD_DP, 2'h1, 3'h4);
		8'hF2, 8'hF3: sx(cbd_pkg::OP_XDATA_WR_IND, 2'h1, 3'h5);
		8'hF0: sx(cbd_pkg::OP_XDATA_WR_DP, 2'h1, 3'h5);
		8'hC0: sx(cbd_pkg::OP_STACK_PUSH, 2'h2, 3'h4);
		8'hD0: sx(cbd_pkg::OP_STACK_POP, 2'h2, 3'h3);
		8'hD6, 8'hD7: sx(cbd_pkg::OP_NIBBLE_EXCHANGE, 2'h1, 3'h3);
		8'b1100_1???: sx(cbd_pkg::OP_BYTE_SWAP_WITH_ACC, 2'h1, 3'h2);
		8'h80: sx(cbd_pkg::OP_SHORT_RELATIVE_JUMP, 2'h2, 3'h3);
		8'h73: sx(cbd_pkg::OP_JUMP_ACC_PLUS_DP, 2'h1, 3'h2);
		8'h60: sx(cbd_pkg::OP_BRANCH_IF_ACC_ZERO, 2'h2, 3'h3);
		8'h70: sx(cbd_pkg::OP_BRANCH_IF_ACC_NONZERO, 2'h2, 3'h3);
		8'h40: sx(cbd_pkg::OP_BRANCH_IF_CARRY, 2'h2, 3'h3);
		8'h50: sx(cbd_pkg::OP_BRANCH_IF_NO_CARRY, 2'h2, 3'h3);
		8'h20: sx(cbd_pkg::OP_BRANCH_IF_BIT_ONE, 2'h3, 3'h4);
		8'h30: sx(cbd_pkg::OP_BRANCH_IF_BIT_ZERO, 2'h3, 3'h4);
		8'h10: sx(cbd_pkg::OP_BRANCH_AND_CLEAR_BIT, 2'h3, 3'h4);
		8'hB5: sx(cbd_pkg::OP_CMP_BRANCH_DIR, 2'h3, 3'h4);
		8'hB4: sx(cbd_pkg::OP_CMP_BRANCH_IMM, 2'h3, 3'h4);
		8'b1011_1???: sx(cbd_pkg::OP_CMP_BRANCH_REG, 2'h3, 3'h4);
		8'b1101_1???: sx(cbd_pkg::OP_DEC_BRANCH_REG, 2'h2, 3'h3);
		8'hD5: sx(cbd_pkg::OP_DEC_BRANCH_DIR, 2'h3, 3'h4);
		8'hC2: sx(cbd_pkg::OP_BIT_CLEAR_OP, 2'h2, 3'h3);
		8'hD2: sx(cbd_pkg::OP_BIT_SET_OP, 2'h2, 3'h3);
		8'hB2: sx(cbd_pkg::OP_BIT_INVERT_OP, 2'h2, 3'h3);
		8'h82: sx(cbd_pkg::OP_LOGICAL_AND_BIT, 2'h2, 3'h2);
		8'h72: sx(cbd_pkg::OP_LOGICAL_OR_BIT, 2'h2, 3'h2);
		8'hB0: sx(cbd_pkg::OP_LOGICAL_AND_NBIT, 2'h2, 3'h2);
		8'hA0: sx(cbd_pkg::OP_LOGICAL_OR_NBIT, 2'h2, 3'h2);
		default: sx(cbd_pkg::OP_NONE, 2'h1, 3'h1);
		endcase
		e_uns = e_op == cbd_pkg::OP_NONE;
	endtask : ref_dec

	// Outcome expected from the conditions seen in the last busy cycle
	task automatic ref_cond();
		{e_br, e_bwe, e_bv, e_cwe, e_cv} = 5'h00;
		case (e_op)
		cbd_pkg::OP_SHORT_RELATIVE_JUMP, cbd_pkg::OP_JUMP_ACC_PLUS_DP: e_br = 1'h1;
		cbd_pkg::OP_BRANCH_IF_ACC_ZERO: e_br = acc_is_zero;
		cbd_pkg::OP_BRANCH_IF_ACC_NONZERO: e_br = !acc_is_zero;
		cbd_pkg::OP_BRANCH_IF_CARRY: e_br = carry_flag;
		cbd_pkg::OP_BRANCH_IF_NO_CARRY: e_br = !carry_flag;
		cbd_pkg::OP_BRANCH_IF_BIT_ONE: e_br = addr_bit;
		cbd_pkg::OP_BRANCH_IF_BIT_ZERO: e_br = !addr_bit;
		cbd_pkg::OP_BRANCH_AND_CLEAR_BIT: {e_br, e_bwe} = {2{addr_bit}};
		cbd_pkg::OP_CMP_BRANCH_DIR, cbd_pkg::OP_CMP_BRANCH_IMM,
		cbd_pkg::OP_CMP_BRANCH_REG: e_br = compare_unequal;
		cbd_pkg::OP_DEC_BRANCH_REG, cbd_pkg::OP_DEC_BRANCH_DIR: e_br = decrement_nonzero;
		cbd_pkg::OP_BIT_CLEAR_OP: e_bwe = 1'h1;
		cbd_pkg::OP_BIT_SET_OP: {e_bwe, e_bv} = 2'h3;
		cbd_pkg::OP_BIT_INVERT_OP: {e_bwe, e_bv} = {1'h1, !addr_bit};
		cbd_pkg::OP_LOGICAL_AND_BIT: {e_cwe, e_cv} = {1'h1, carry_flag & addr_bit};
		cbd_pkg::OP_LOGICAL_OR_BIT: {e_cwe, e_cv} = {1'h1, carry_flag | addr_bit};
		cbd_pkg::OP_LOGICAL_AND_NBIT: {e_cwe, e_cv} = {1'h1, carry_flag & !addr_bit};
		cbd_pkg::OP_LOGICAL_OR_NBIT: {e_cwe, e_cv} = {1'h1, carry_flag | !addr_bit};
		default: ;
		endcase
	endtask : ref_cond

	// Random datapath conditions, power control and memory stalls
	always @(posedge sys_clk)
	begin
		#1;
		r = $random(seed);
		{acc_is_zero, carry_flag, addr_bit, compare_unequal, decrement_nonzero} <= r[4:0];
		pcon_value <= r[15:8];
		hold_off <= slow & r[20];
	end

	// Monitor: outputs are read at the edge, before the design updates them
	always @(posedge sys_clk)
	begin
		if (!resetn)
			cnt = 4'h0;
		else
		begin
			if (busy === 1'h1)
			begin
				cnt++;
				`CHK(fetch_req, 1'h0, "fetch while busy")
				`CHK(ext_rd, xr, "external read strobe")
				`CHK(ext_wr, xw, "external write strobe")
				if (cnt == {1'h0, e_cyc})
					ref_cond();
			end
			if (done === 1'h1)
			begin
				n_done++;
				`CHK(cnt, {1'h0, e_cyc}, "busy cycles")
				`CHK(op_code, e_op, "operation")
				`CHK(instr_len, e_len, "length")
				`CHK(instr_cycles, e_cyc, "cycle count")
				`CHK(reg_idx, e_idx, "register index")
				`CHK(unsupported, e_uns, "unsupported flag")
				`CHK(branch_taken, e_br, "branch taken")
				`CHK(bit_we, e_bwe, "bit write")
				`CHK(carry_we, e_cwe, "carry write")
				if (e_bwe)
					`CHK(bit_val, e_bv, "bit value")
				if (e_cwe)
					`CHK(carry_val, e_cv, "carry value")
				if (xr || xw)
				begin
					`CHK(ext_wide_addr, xwide, "address form")
					`CHK(ext_to_code, e_pmw, "program memory select")
				end
				cnt = 4'h0;
			end
			if (fetch_req === 1'h1 && fetch_valid === 1'h1)
			begin
				ref_dec(fetch_data);
				e_pmw = pcon_value[4];
			end
		end
	end

	task tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	task run_prog(input int n, input logic s, input string name);
		@(posedge sys_clk);
		#1;
		prog_len = n[8:0];
		slow = s;
		n_done = 0;
		run = 1'h1;
		// Look only after an edge, once the memory has dropped the old pointer
		for (i = 0; i < 5000; i++)
		begin
			@(posedge sys_clk);
			#2;
			if (i_mem.ptr == n && fetch_req === 1'h1 && busy === 1'h0)
				break;
		end
		if (i == 5000)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t timeout in %s", $time, name);
			tally_and_finish();
		end
		else
		begin
			@(posedge sys_clk);
			#1;
			run = 1'h0;
			`CHK(n_done, n, "instruction count")
			$display("test %s finished", name);
		end
	endtask : run_prog

	initial
	begin
		repeat (6) @(posedge sys_clk);
		#1;
		resetn = 1'h1;
		for (int k = 0; k < 256; k++)
			i_mem.prog[k] = k[7:0];
		run_prog(256, 1'h0, "all_opcodes");
		for (int k = 0; k < 256; k++)
			i_mem.prog[k] = 8'($random(seed));
		run_prog(256, 1'h1, "random_stalled");
		for (int k = 0; k < 4; k++)
			i_mem.prog[k] = 8'hF0;
		@(posedge sys_clk);
		#1;
		prog_len = 9'h004;
		run = 1'h1;
		repeat (4) @(posedge sys_clk);
		#1;
		run = 1'h0;
		resetn = 1'h0;
		#2;
		`CHK(fetch_req, 1'h1, "reset fetch request")
		`CHK({busy, done, ext_wr}, 3'h0, "reset strobes")
		`CHK(op_code, cbd_pkg::OP_NONE, "reset operation")
		repeat (2) @(posedge sys_clk);
		#1;
		resetn = 1'h1;
		$display("test reset_mid_run finished");
		for (int k = 0; k < 48; k++)
			i_mem.prog[k] = k[0] ? (k[1] ? 8'hF2 : 8'hE3) : (k[2] ? 8'hF0 : 8'hE0);
		run_prog(48, 1'h0, "external_back_to_back");
		tally_and_finish();
	end
endmodule : tb_cbd_sequencer
